// File: hw/sys_irq_consts.svh
`ifndef SYS_IRQ_CONSTS_SVH
`define SYS_IRQ_CONSTS_SVH
// Register byte offsets
`define REG_PENDING   8'h00
`define REG_MASK      8'h04
`define REG_ROUTE     8'h08
`define REG_FAST_VEC  8'h0C
`define REG_NORM_VEC  8'h10
`define REG_SW_TRIG   8'h14
`define REG_CFG_FIRST 8'h20
`define REG_FLASH_BASE 8'h20
`define REG_FLASH_SIZE 8'h24
`define REG_ROM_BASE  8'h28
`define REG_ROM_SIZE  8'h2C
`define REG_RAM_BASE  8'h30
`define REG_RAM_SIZE  8'h34
`define REG_PER_BASE  8'h38
`define REG_PROT_ALLOW 8'h3C
`define REG_PROT_CTRL 8'h40
// Reset values
`define RST_FLASH_BASE 32'h0001_0000
`define RST_FLASH_SIZE 4'h5
`define RST_ROM_BASE  32'h0000_0000
`define RST_ROM_SIZE  4'h6
`define RST_RAM_BASE  32'h0001_9000
`define RST_RAM_SIZE  4'h2
`define RST_PER_BASE  32'hFFF7_E000
`define RST_ALLOW     11'h7FF
// Decode geometry
`define WIN_UNIT      32'h0000_0400
`define SIZE_MAX      4'hE
`define PER_LSB       13
// Channel map
`define CH_BROWNOUT   0
`define CH_EXT_PIN    1
`define CH_WD_EXPIRY  2
`define CH_WD_HALF    3
`define CH_SER_ERR    4
`define CH_SER_FIRST  5
`define CH_PMBUS      9
`define CH_ADC_THR    10
`define CH_FE_FIRST   11
`define CH_TPWM_FIRST 14
`define CH_LT_WRAP    18
`define CH_LT_FIRST   19
`define CH_PCM        23
`define CH_ADC_DONE   24
`define CH_FAULT_MUX  25
`define CH_PWM_FIRST  26
`define CH_FAULT_PIN  30
`define CH_SOFTWARE   31
// Bus responses
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2
`endif

// File: hw/sys_irq_pkg.sv
package sys_irq_pkg;
  typedef enum logic [1:0] {
    PH_COLLECT = 2'b00,
    PH_STALL   = 2'b01,
    PH_RESP    = 2'b10
  } axi_phase_type;
endpackage

// File: hw/system_interrupt_and_decode.sv
// What this block does
// - Thirty-two independent request channels are latched as pending.
// - Two processor request levels, fast above normal.
// - Per level, a readable index of the highest pending channel.
// - Precedence rises with channel number; 31 highest, 0 lowest.
// - Each channel has its own mask; masked channels signal nothing.
// - Channels 0-3: brownout, external pin, watchdog expiry, watchdog halfway.
// - Channel 4 serial errors, 5-8 serial rx/tx, 9 PMBus, 10 ADC threshold, 11-13 front ends.
// - Channels 14-17: timer PWM units 3 down to 0.
// - Channels 18-22 long timer events, 23 power/current mode, 24 ADC done.
// - Channels 26-29: pulse-width modulator units 3 down to 0.
// - Channel 25 fault mux, 30 fault pin, 31 software trigger.
// - Flash, ROM, RAM selects with configurable base and 1 kB to 16 MB size.
// - Accesses to decoder configuration take one extra wait state.
// - Decoder configuration writes are ignored unless privileged.
// - Eight peripheral selects of 1 kB each; peripheral cycles are extended.
// - Per-module user permission; illegal access raises fault or reset.
`include "sys_irq_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module system_interrupt_and_decode #(
  parameter int ADDR_W = 8
) (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic [ADDR_W-1:0]   awaddr,
  input  wire logic [2:0]          awprot,
  input  wire logic                awvalid,
  output logic                     awready,
  input  wire logic [31:0]         wdata,
  input  wire logic [3:0]          wstrb,
  input  wire logic                wvalid,
  output logic                     wready,
  output logic [1:0]               bresp,
  output logic                     bvalid,
  input  wire logic                bready,
  input  wire logic [ADDR_W-1:0]   araddr,
  input  wire logic [2:0]          arprot,
  input  wire logic                arvalid,
  output logic                     arready,
  output logic [31:0]              rdata,
  output logic [1:0]               rresp,
  output logic                     rvalid,
  input  wire logic                rready,
  input  wire logic                brownout_request,
  input  wire logic                ext_pin_request,
  input  wire logic                watchdog_expiry_request,
  input  wire logic                watchdog_halfway_request,
  input  wire logic                serial_error_request,
  input  wire logic [3:0]          serial_data_request,
  input  wire logic                pmbus_request,
  input  wire logic                adc_threshold_request,
  input  wire logic [2:0]          front_end_request,
  input  wire logic [3:0]          timer_pwm_request,
  input  wire logic                long_timer_wrap_request,
  input  wire logic [3:0]          long_timer_event_request,
  input  wire logic                power_current_mode_request,
  input  wire logic                adc_done_request,
  input  wire logic                fault_mux_request,
  input  wire logic [3:0]          pwm_unit_request,
  input  wire logic                fault_pin_request,
  output logic                     fast_irq_level,
  output logic                     normal_irq_level,
  input  wire logic [31:0]         cpu_addr,
  input  wire logic                cpu_access,
  input  wire logic                cpu_user,
  output logic [2:0]               mem_sel,
  output logic [7:0]               periph_sel,
  output logic                     periph_wait,
  output logic                     prot_fault,
  output logic                     prot_reset
);
  import sys_irq_pkg::*;

  generate
    if (ADDR_W < 8 || ADDR_W > 32) begin : bad_width
      $error("ADDR_W must lie between 8 and 32");
    end
  endgenerate

  function automatic logic [5:0] top_channel(input logic [31:0] v);
    logic [5:0] r;
    r = 6'h00;
    for (int i = 0; i < 32; i++) begin
      if (v[i]) begin
        r = {1'b1, 5'(i)};
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] lanes(input logic [3:0] s);
    return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  function automatic logic in_window(input logic [31:0] a, input logic [31:0] b,
                                     input logic [3:0] sz);
    logic [31:0] span;
    span = `WIN_UNIT << sz;
    return ((a ^ b) & ~(span - 32'h1)) == 32'h0;
  endfunction

  function automatic logic is_cfg(input logic [7:0] a);
    return a >= `REG_CFG_FIRST;
  endfunction

  logic [31:0]   pending;
  logic [31:0]   mask;
  logic [31:0]   route;
  logic [31:0]   mem_base [3];
  logic [3:0]    mem_size [3];
  logic [31:0]   periph_base;
  logic [10:0]   allow;
  logic          prot_to_reset;
  logic [5:0]    fast_vec;
  logic [5:0]    normal_vec;
  logic [31:0]   raw;
  logic [31:0]   clear;
  axi_phase_type wr_phase;
  axi_phase_type rd_phase;
  logic          aw_have;
  logic          w_have;
  logic          ar_have;
  logic [7:0]    aw_off;
  logic          aw_priv;
  logic [31:0]   w_word;
  logic [3:0]    w_lanes;
  logic [7:0]    ar_off;
  logic          wr_fire;
  logic          wr_known;
  logic          wr_en;
  logic [31:0]   rd_word;
  logic          rd_known;
  logic [2:0]    mem_hit;
  logic [7:0]    per_hit;
  logic          violation;

  // Request assembly
  always_comb begin
    raw = 32'h0;
    raw[`CH_BROWNOUT] = brownout_request;
    raw[`CH_EXT_PIN] = ext_pin_request;
    raw[`CH_WD_EXPIRY] = watchdog_expiry_request;
    raw[`CH_WD_HALF] = watchdog_halfway_request;
    raw[`CH_SER_ERR] = serial_error_request;
    raw[`CH_SER_FIRST +: 4] = serial_data_request;
    raw[`CH_PMBUS] = pmbus_request;
    raw[`CH_ADC_THR] = adc_threshold_request;
    raw[`CH_FE_FIRST +: 3] = front_end_request;
    for (int u = 0; u < 4; u++) begin
      raw[`CH_TPWM_FIRST + 3 - u] = timer_pwm_request[u];
      raw[`CH_PWM_FIRST + 3 - u] = pwm_unit_request[u];
    end
    raw[`CH_LT_WRAP] = long_timer_wrap_request;
    raw[`CH_LT_FIRST +: 4] = long_timer_event_request;
    raw[`CH_PCM] = power_current_mode_request;
    raw[`CH_ADC_DONE] = adc_done_request;
    raw[`CH_FAULT_MUX] = fault_mux_request;
    raw[`CH_FAULT_PIN] = fault_pin_request;
    raw[`CH_SOFTWARE] = wr_en && aw_off == `REG_SW_TRIG && w_word[0];
    clear = (wr_en && aw_off == `REG_PENDING) ? (w_word & lanes(w_lanes)) : 32'h0;
  end

  // Write decode
  always_comb begin
    wr_fire = (wr_phase == PH_COLLECT && aw_have && w_have && !is_cfg(aw_off))
              || wr_phase == PH_STALL;
    unique case (aw_off)
      `REG_PENDING, `REG_MASK, `REG_ROUTE, `REG_SW_TRIG, `REG_FLASH_BASE,
      `REG_FLASH_SIZE, `REG_ROM_BASE, `REG_ROM_SIZE, `REG_RAM_BASE, `REG_RAM_SIZE,
      `REG_PER_BASE, `REG_PROT_ALLOW, `REG_PROT_CTRL: wr_known = 1'b1;
      default: wr_known = 1'b0;
    endcase
    wr_en = wr_fire && wr_known && (!is_cfg(aw_off) || aw_priv);
  end

  // Pending latch, set wins over clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pending <= 32'h0;
    end else begin
      pending <= (pending & ~clear) | raw;
    end
  end

  // Configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask <= 32'h0;
      route <= 32'h0;
      mem_base[0] <= `RST_FLASH_BASE;
      mem_size[0] <= `RST_FLASH_SIZE;
      mem_base[1] <= `RST_ROM_BASE;
      mem_size[1] <= `RST_ROM_SIZE;
      mem_base[2] <= `RST_RAM_BASE;
      mem_size[2] <= `RST_RAM_SIZE;
      periph_base <= `RST_PER_BASE;
      allow <= `RST_ALLOW;
      prot_to_reset <= 1'b0;
    end else if (wr_en) begin
      unique case (aw_off)
        `REG_MASK: mask <= (mask & ~lanes(w_lanes)) | (w_word & lanes(w_lanes));
        `REG_ROUTE: route <= (route & ~lanes(w_lanes)) | (w_word & lanes(w_lanes));
        `REG_FLASH_BASE: mem_base[0] <= w_word;
        `REG_ROM_BASE: mem_base[1] <= w_word;
        `REG_RAM_BASE: mem_base[2] <= w_word;
        `REG_FLASH_SIZE: mem_size[0] <= w_word[3:0] > `SIZE_MAX ? `SIZE_MAX : w_word[3:0];
        `REG_ROM_SIZE: mem_size[1] <= w_word[3:0] > `SIZE_MAX ? `SIZE_MAX : w_word[3:0];
        `REG_RAM_SIZE: mem_size[2] <= w_word[3:0] > `SIZE_MAX ? `SIZE_MAX : w_word[3:0];
        `REG_PER_BASE: periph_base <= w_word;
        `REG_PROT_ALLOW: allow <= w_word[10:0];
        `REG_PROT_CTRL: prot_to_reset <= w_word[0];
        default: ;
      endcase
    end
  end

  // Level outputs and vector indices
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fast_irq_level <= 1'b0;
      normal_irq_level <= 1'b0;
      fast_vec <= 6'h00;
      normal_vec <= 6'h00;
    end else begin
      fast_irq_level <= |(pending & mask & route);
      normal_irq_level <= |(pending & mask & ~route);
      fast_vec <= top_channel(pending & mask & route);
      normal_vec <= top_channel(pending & mask & ~route);
    end
  end

  // Write channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_phase <= PH_COLLECT;
      awready <= 1'b1;
      wready <= 1'b1;
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_off <= 8'h00;
      aw_priv <= 1'b0;
      w_word <= 32'h0;
      w_lanes <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_have <= 1'b1;
        awready <= 1'b0;
        aw_off <= awaddr[7:0];
        aw_priv <= awprot[0];
      end
      if (wvalid && wready) begin
        w_have <= 1'b1;
        wready <= 1'b0;
        w_word <= wdata;
        w_lanes <= wstrb;
      end
      unique case (wr_phase)
        PH_COLLECT: if (aw_have && w_have) begin
          wr_phase <= is_cfg(aw_off) ? PH_STALL : PH_RESP;
        end
        PH_STALL: wr_phase <= PH_RESP;
        PH_RESP: if (bvalid && bready) begin
          wr_phase <= PH_COLLECT;
          aw_have <= 1'b0;
          w_have <= 1'b0;
          awready <= 1'b1;
          wready <= 1'b1;
        end
        default: wr_phase <= PH_COLLECT;
      endcase
      if (wr_fire) begin
        bvalid <= 1'b1;
        bresp <= wr_en ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Read decode
  always_comb begin
    rd_known = 1'b1;
    unique case (ar_off)
      `REG_PENDING: rd_word = pending;
      `REG_MASK: rd_word = mask;
      `REG_ROUTE: rd_word = route;
      `REG_FAST_VEC: rd_word = {23'h0, fast_vec[5], 3'h0, fast_vec[4:0]};
      `REG_NORM_VEC: rd_word = {23'h0, normal_vec[5], 3'h0, normal_vec[4:0]};
      `REG_SW_TRIG: rd_word = 32'h0;
      `REG_FLASH_BASE: rd_word = mem_base[0];
      `REG_FLASH_SIZE: rd_word = {28'h0, mem_size[0]};
      `REG_ROM_BASE: rd_word = mem_base[1];
      `REG_ROM_SIZE: rd_word = {28'h0, mem_size[1]};
      `REG_RAM_BASE: rd_word = mem_base[2];
      `REG_RAM_SIZE: rd_word = {28'h0, mem_size[2]};
      `REG_PER_BASE: rd_word = periph_base;
      `REG_PROT_ALLOW: rd_word = {21'h0, allow};
      `REG_PROT_CTRL: rd_word = {31'h0, prot_to_reset};
      default: begin
        rd_word = 32'h0;
        rd_known = 1'b0;
      end
    endcase
  end

  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_phase <= PH_COLLECT;
      arready <= 1'b1;
      ar_have <= 1'b0;
      ar_off <= 8'h00;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= `RESP_OKAY;
    end else begin
      if (arvalid && arready) begin
        ar_have <= 1'b1;
        arready <= 1'b0;
        ar_off <= araddr[7:0];
      end
      unique case (rd_phase)
        PH_COLLECT: if (ar_have) begin
          rd_phase <= is_cfg(ar_off) ? PH_STALL : PH_RESP;
        end
        PH_STALL: rd_phase <= PH_RESP;
        PH_RESP: if (rvalid && rready) begin
          rd_phase <= PH_COLLECT;
          ar_have <= 1'b0;
          arready <= 1'b1;
        end
        default: rd_phase <= PH_COLLECT;
      endcase
      if ((rd_phase == PH_COLLECT && ar_have && !is_cfg(ar_off)) || rd_phase == PH_STALL) begin
        rvalid <= 1'b1;
        rdata <= rd_word;
        rresp <= rd_known ? `RESP_OKAY : `RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // Processor-side decode and protection
  always_comb begin
    for (int m = 0; m < 3; m++) begin
      mem_hit[m] = in_window(cpu_addr, mem_base[m], mem_size[m]);
    end
    per_hit = 8'h00;
    if (cpu_addr[31:`PER_LSB] == periph_base[31:`PER_LSB]) begin
      per_hit[cpu_addr[`PER_LSB-1 -: 3]] = 1'b1;
    end
    violation = cpu_access && ({per_hit, mem_hit} == 11'h0
                || (cpu_user && ({per_hit, mem_hit} & ~allow) != 11'h0));
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mem_sel <= 3'h0;
      periph_sel <= 8'h00;
      periph_wait <= 1'b0;
      prot_fault <= 1'b0;
      prot_reset <= 1'b0;
    end else begin
      mem_sel <= cpu_access ? mem_hit : 3'h0;
      periph_sel <= cpu_access ? per_hit : 8'h00;
      periph_wait <= cpu_access && per_hit != 8'h00 && !periph_wait;
      prot_fault <= violation && !prot_to_reset;
      prot_reset <= violation && prot_to_reset;
    end
  end

  fast_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
    |(pending & mask & route) |=> fast_irq_level) else $error("fast level missing");
  normal_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
    |(pending & mask & ~route) |=> normal_irq_level) else $error("normal level missing");
  mask_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (pending & mask) == 32'h0 |=> !fast_irq_level && !normal_irq_level)
    else $error("masked channel signalled");
  fast_top_a: assert property (@(posedge aclk) disable iff (!aresetn)
    fast_vec[5] |-> (($past(pending) & $past(mask) & $past(route)) >> fast_vec[4:0]) == 32'h1)
    else $error("fast index not highest");
  pend_latch_a: assert property (@(posedge aclk) disable iff (!aresetn)
    raw != 32'h0 |=> (pending & $past(raw)) == $past(raw)) else $error("request lost");
  cfg_stall_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_phase == PH_COLLECT && aw_have && w_have && is_cfg(aw_off)
    |=> !bvalid ##1 bvalid) else $error("wait state missing");
  user_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire && is_cfg(aw_off) && !aw_priv |=> $stable(mem_base[0]) && bresp == `RESP_SLVERR)
    else $error("user write accepted");
  prot_out_a: assert property (@(posedge aclk) disable iff (!aresetn)
    violation |=> (prot_fault != prot_reset)) else $error("violation not raised");
  periph_one_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cpu_access && per_hit != 8'h00 |=> $onehot(periph_sel) && (periph_wait != $past(periph_wait)))
    else $error("peripheral select wrong");
  sw_trig_a: assert property (@(posedge aclk) disable iff (!aresetn)
    raw[`CH_SOFTWARE] |=> pending[`CH_SOFTWARE]) else $error("software request lost");

  both_levels_c: cover property (@(posedge aclk) fast_irq_level && normal_irq_level);
  sw_irq_c: cover property (@(posedge aclk) raw[`CH_SOFTWARE] ##2 normal_irq_level);
  stall_c: cover property (@(posedge aclk) rd_phase == PH_STALL);
  fault_c: cover property (@(posedge aclk) prot_fault);
endmodule
`default_nettype wire

// File: verification/irq_source_model.sv
`timescale 1ns/100ps
`default_nettype none
// Peripheral request sources; one registered pulse per bit of src_vec
module irq_source_model (
  input  wire logic        aclk,
  input  wire logic [30:0] src_vec,
  output logic             brownout_request,
  output logic             ext_pin_request,
  output logic             watchdog_expiry_request,
  output logic             watchdog_halfway_request,
  output logic             serial_error_request,
  output logic [3:0]       serial_data_request,
  output logic             pmbus_request,
  output logic             adc_threshold_request,
  output logic [2:0]       front_end_request,
  output logic [3:0]       timer_pwm_request,
  output logic             long_timer_wrap_request,
  output logic [3:0]       long_timer_event_request,
  output logic             power_current_mode_request,
  output logic             adc_done_request,
  output logic             fault_mux_request,
  output logic [3:0]       pwm_unit_request,
  output logic             fault_pin_request
);
  logic [30:0] v;
  always_ff @(posedge aclk) begin
    v <= src_vec;
  end
  assign {watchdog_halfway_request, watchdog_expiry_request} = v[3:2];
  assign {ext_pin_request, brownout_request} = v[1:0];
  assign serial_error_request = v[4];
  assign serial_data_request = v[8:5];
  assign {adc_threshold_request, pmbus_request} = v[10:9];
  assign front_end_request = v[13:11];
  assign timer_pwm_request = {v[14], v[15], v[16], v[17]};
  assign long_timer_wrap_request = v[18];
  assign long_timer_event_request = v[22:19];
  assign {adc_done_request, power_current_mode_request} = v[24:23];
  assign fault_mux_request = v[25];
  assign pwm_unit_request = {v[26], v[27], v[28], v[29]};
  assign fault_pin_request = v[30];
endmodule
`default_nettype wire

// File: verification/test_system_interrupt_and_decode.sv
`include "sys_irq_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module test_system_interrupt_and_decode;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, cpu_access, cpu_user;
  logic        fast_irq_level, normal_irq_level, periph_wait, prot_fault, prot_reset;
  logic [7:0]  awaddr, araddr, periph_sel;
  logic [2:0]  awprot, arprot, mem_sel, front_end_request;
  logic [31:0] wdata, rdata, cpu_addr, rd;
  logic [3:0]  wstrb, serial_data_request, timer_pwm_request, long_timer_event_request;
  logic [3:0]  pwm_unit_request;
  logic [1:0]  bresp, rresp;
  logic        brownout_request, ext_pin_request, watchdog_expiry_request;
  logic        watchdog_halfway_request, serial_error_request, pmbus_request;
  logic        adc_threshold_request, long_timer_wrap_request, power_current_mode_request;
  logic        adc_done_request, fault_mux_request, fault_pin_request;
  logic [30:0] src_vec;
  int          n_fail, cmp_count, c_norm, c_cfg;

  system_interrupt_and_decode i_dut (.*);
  irq_source_model i_src (.*);

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  task automatic print_verdict;
    $display("Comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(string name, logic [31:0] exp, logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic timeout(string name);
    n_fail++;
    $display("ERROR %s expected handshake seen none", name);
    print_verdict();
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d, logic [2:0] p, logic [1:0] er,
                    output int cyc);
    int k;
    cyc = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awprot <= p;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 20 && !bvalid; k++) begin
      @(posedge aclk);
      cyc++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end
    if (!bvalid) timeout("bvalid");
    bready <= 1'b0;
    check("bresp", {30'h0, er}, {30'h0, bresp});
  endtask

  task automatic rdr(logic [7:0] a, logic [1:0] er, output logic [31:0] d);
    int k;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 20 && !rvalid; k++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end
    if (!rvalid) timeout("rvalid");
    rready <= 1'b0;
    d = rdata;
    check("rresp", {30'h0, er}, {30'h0, rresp});
  endtask

  task automatic probe(logic [31:0] a, logic u);
    @(posedge aclk);
    cpu_addr <= a;
    cpu_user <= u;
    cpu_access <= 1'b1;
    @(posedge aclk);
    cpu_access <= 1'b0;
    #1;
  endtask

  task automatic fire(logic [30:0] v);
    @(posedge aclk);
    src_vec <= v;
    @(posedge aclk);
    src_vec <= 31'h0;
    repeat (4) @(posedge aclk);
  endtask

  task automatic t_reset;
    rdr(`REG_MASK, `RESP_OKAY, rd);
    check("mask", 32'h0, rd);
    rdr(`REG_FLASH_BASE, `RESP_OKAY, rd);
    check("flash base", `RST_FLASH_BASE, rd);
    rdr(`REG_PER_BASE, `RESP_OKAY, rd);
    check("periph base", `RST_PER_BASE, rd);
    rdr(`REG_PROT_ALLOW, `RESP_OKAY, rd);
    check("allow", {21'h0, `RST_ALLOW}, rd);
    rdr(8'h18, `RESP_SLVERR, rd);
    wr(`REG_FAST_VEC, 32'h1F, 3'h1, `RESP_SLVERR, c_norm);
  endtask

  task automatic t_channels;
    int ch;
    wr(`REG_MASK, 32'hFFFF_FFFF, 3'h1, `RESP_OKAY, c_norm);
    for (ch = 0; ch < 32; ch++) begin
      if (ch < 31) fire(31'h1 << ch);
      else wr(`REG_SW_TRIG, 32'h1, 3'h1, `RESP_OKAY, c_norm);
      rdr(`REG_NORM_VEC, `RESP_OKAY, rd);
      check("normal vector", 32'h100 | ch, rd);
      check("normal level", 32'h1, {31'h0, normal_irq_level});
      check("fast level", 32'h0, {31'h0, fast_irq_level});
      wr(`REG_PENDING, 32'h1 << ch, 3'h1, `RESP_OKAY, c_norm);
      repeat (3) @(posedge aclk);
      check("level cleared", 32'h0, {31'h0, normal_irq_level});
    end
  endtask

  task automatic t_precedence;
    wr(`REG_ROUTE, 32'h8, 3'h1, `RESP_OKAY, c_norm);
    fire(31'h0010_0009);
    rdr(`REG_NORM_VEC, `RESP_OKAY, rd);
    check("normal vector", 32'h114, rd);
    rdr(`REG_FAST_VEC, `RESP_OKAY, rd);
    check("fast vector", 32'h103, rd);
    check("fast level", 32'h1, {31'h0, fast_irq_level});
    wr(`REG_MASK, 32'hFFEF_FFFF, 3'h1, `RESP_OKAY, c_norm);
    rdr(`REG_NORM_VEC, `RESP_OKAY, rd);
    check("masked vector", 32'h100, rd);
    wr(`REG_MASK, 32'hFFEF_FFFE, 3'h1, `RESP_OKAY, c_norm);
    rdr(`REG_NORM_VEC, `RESP_OKAY, rd);
    check("vector valid", 32'h0, rd & 32'h100);
    check("normal level", 32'h0, {31'h0, normal_irq_level});
    wr(`REG_PENDING, 32'hFFFF_FFFF, 3'h1, `RESP_OKAY, c_norm);
  endtask

  task automatic t_decoder;
    int k;
    probe(32'h0001_0000, 1'b0);
    check("flash select", 32'h1, {29'h0, mem_sel});
    probe(32'h0000_0000, 1'b0);
    check("rom select", 32'h2, {29'h0, mem_sel});
    probe(32'h0001_9000, 1'b0);
    check("ram select", 32'h4, {29'h0, mem_sel});
    for (k = 0; k < 8; k++) begin
      probe(`RST_PER_BASE + k * 32'h400, 1'b0);
      check("periph select", 32'h1 << k, {24'h0, periph_sel});
      check("periph wait", 32'h1, {31'h0, periph_wait});
    end
    probe(32'h8000_0000, 1'b0);
    check("fault", 32'h1, {31'h0, prot_fault});
    wr(`REG_PROT_ALLOW, 32'h7FE, 3'h1, `RESP_OKAY, c_cfg);
    check("wait state", c_norm + 1, c_cfg);
    probe(32'h0001_0000, 1'b1);
    check("user fault", 32'h1, {31'h0, prot_fault});
    wr(`REG_PROT_ALLOW, 32'h7FF, 3'h0, `RESP_SLVERR, c_cfg);
    rdr(`REG_PROT_ALLOW, `RESP_OKAY, rd);
    check("allow kept", 32'h7FE, rd);
    wr(`REG_FLASH_SIZE, 32'h0, 3'h1, `RESP_OKAY, c_cfg);
    probe(32'h0001_0400, 1'b0);
    check("size fault", 32'h1, {31'h0, prot_fault});
    wr(`REG_PROT_CTRL, 32'h1, 3'h1, `RESP_OKAY, c_cfg);
    probe(32'h8000_0000, 1'b0);
    check("prot reset", 32'h1, {31'h0, prot_reset});
  endtask

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, cpu_access, cpu_user} = '0;
    {awaddr, araddr, awprot, arprot, wdata, wstrb, cpu_addr, src_vec} = '0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_channels();
    t_precedence();
    t_decoder();
    print_verdict();
  end
endmodule
`default_nettype wire
